// [logic/line_event_monitor_pkg.sv]
`default_nettype none
package line_event_monitor_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned ADR_W = 9;
  localparam logic [6:0] IDX_LINE = 7'h35;
  localparam logic [6:0] IDX_GAIN = 7'h3f;
  localparam logic [6:0] IDX_HOOK = 7'h40;
  localparam logic [6:0] IDX_TONE = 7'h41;
  localparam logic [6:0] IDX_RING = 7'h42;
  localparam logic [6:0] IDX_STAT = 7'h43;
  localparam logic [6:0] IDX_HOOK2 = 7'h4f;
  localparam logic [6:0] IDX_QUENCH = 7'h6b;
  localparam int OH_BIT = 0;
  localparam int ONHOOK_MONITOR_ENABLE_BIT = 3;
  localparam int RNEG_BIT = 5;
  localparam int RPOS_BIT = 6;
  localparam int HS_BIT = 6;
  localparam int DET_BIT = 0;
  localparam int OVR_BIT = 1;
  localparam int TDE_BIT = 2;
  localparam int RCD_BIT = 4;
  localparam int FW_BIT = 1;
  localparam int IND_BIT = 2;
  localparam int CAL_BIT = 4;
  localparam int HS2_BIT = 3;
  localparam int SQ0_BIT = 4;
  localparam int SQ1_BIT = 6;
  localparam logic [7:0] LEVEL_FULL = 8'hff;
  localparam int unsigned CAL_TIME_MS = 256;
  localparam int unsigned CAL_CYCLES = CAL_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned RAMP_STEP_US = 10;
  localparam int unsigned RAMP_STEP_CYCLES = RAMP_STEP_US * CLK_MHZ;
  typedef enum logic [1:0] {
    HOOK_ON = 2'b00,
    HOOK_OFF = 2'b01,
    HOOK_RAMP = 2'b10
  } hook_type;
  typedef struct packed {
    logic ringAbovePos;
    logic ringBelowNeg;
    logic amplitudeOver;
    logic supplyDepressed;
    logic toneActive;
  } line_in_type;
  typedef struct packed {
    logic offhook;
    logic [7:0] loopLevel;
    logic term800;
    logic monitorActive;
    logic [2:0] monitorGain;
    logic ringDetect;
    logic calBusy;
    logic txPermit;
    logic rcalDisable;
  } line_out_type;
endpackage : line_event_monitor_pkg
`default_nettype wire

// [logic/line_event_monitor.sv]
// Implementation choices: the Wishbone slave port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module line_event_monitor
  import line_event_monitor_pkg::*;
#(
  parameter int unsigned CAL_COUNT = CAL_CYCLES,
  parameter int unsigned STEP_COUNT = RAMP_STEP_CYCLES
)(
  input wire logic clk,
  input wire logic reset,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire line_in_type lineIn,
  output var line_out_type lineOut
);
  line_in_type meta_q, sync_q;
  logic ack_q, ack_d, calBusy_q, calBusy_d;
  logic [31:0] dat_q, dat_d, step_q, step_d, cal_q, cal_d, stepLimit;
  logic oh_q, oh_d, onhook_monitor_enable_q, onhook_monitor_enable_d, tde_q, tde_d, rcd_q, rcd_d;
  logic fw_q, fw_d, hs_q, hs_d, hs2_q, hs2_d;
  logic [1:0] sq_q, sq_d;
  logic [2:0] gain_q, gain_d;
  logic ovr_q, ovr_d, det_q, det_d, ind_q, ind_d;
  logic rpos_q, rpos_d, rneg_q, rneg_d;
  hook_type hook_q, hook_d;
  logic [7:0] level_q, level_d;
  line_out_type out_q, out_d;
  logic access, wrLow, slow, toneOn;
  logic [6:0] idx;
  logic [2:0] shift;

  assign access = cyc_i && stb_i && !ack_q;
  assign idx = adr_i[ADR_W-1:2];
  assign wrLow = access && we_i && sel_i[0];
  assign slow = hs_q || hs2_q || (sq_q != 2'b00);
  assign toneOn = tde_q && hook_q == HOOK_OFF;
  assign shift = 3'(sq_q) + 3'(hs_q) + 3'(hs2_q);
  assign stepLimit = STEP_COUNT << shift;

  // Register file and bus answer; one-cycle ack, never two in a row
  always_comb
  begin
    ack_d = access;
    dat_d = '0;
    oh_d = oh_q;
    onhook_monitor_enable_d = onhook_monitor_enable_q;
    tde_d = tde_q;
    rcd_d = rcd_q;
    fw_d = fw_q;
    hs_d = hs_q;
    hs2_d = hs2_q;
    sq_d = sq_q;
    gain_d = gain_q;
    ovr_d = ovr_q;
    det_d = det_q;
    if (wrLow && idx == IDX_TONE)
    begin
      tde_d = dat_i[TDE_BIT];
      rcd_d = dat_i[RCD_BIT];
      if (!dat_i[OVR_BIT])
        ovr_d = 1'b0;
      if (!dat_i[DET_BIT])
        det_d = 1'b0;
    end
    if (wrLow)
    begin
      case (idx)
        IDX_LINE:
        begin
          oh_d = dat_i[OH_BIT];
          onhook_monitor_enable_d = dat_i[ONHOOK_MONITOR_ENABLE_BIT];
        end
        IDX_GAIN: gain_d = dat_i[2:0];
        IDX_HOOK: hs_d = dat_i[HS_BIT];
        IDX_RING: fw_d = dat_i[FW_BIT];
        IDX_HOOK2: hs2_d = dat_i[HS2_BIT];
        IDX_QUENCH: sq_d = {dat_i[SQ1_BIT], dat_i[SQ0_BIT]};
        default: ;
      endcase
    end
    // Hardware set wins over a clearing write in the same cycle
    if (toneOn && sync_q.amplitudeOver)
      ovr_d = 1'b1;
    if (toneOn && sync_q.supplyDepressed)
      det_d = 1'b1;
    ind_d = toneOn && sync_q.toneActive;
    rpos_d = sync_q.ringAbovePos;
    rneg_d = sync_q.ringBelowNeg;
    if (access && !we_i)
    begin
      case (idx)
        IDX_LINE:
        begin
          dat_d[OH_BIT] = oh_q;
          dat_d[ONHOOK_MONITOR_ENABLE_BIT] = onhook_monitor_enable_q;
          dat_d[RPOS_BIT] = rpos_q;
          dat_d[RNEG_BIT] = rneg_q;
        end
        IDX_GAIN: dat_d[2:0] = gain_q;
        IDX_HOOK: dat_d[HS_BIT] = hs_q;
        IDX_TONE:
        begin
          dat_d[TDE_BIT] = tde_q;
          dat_d[RCD_BIT] = rcd_q;
          dat_d[OVR_BIT] = ovr_q;
          dat_d[DET_BIT] = det_q;
        end
        IDX_RING: dat_d[FW_BIT] = fw_q;
        IDX_STAT:
        begin
          dat_d[IND_BIT] = ind_q;
          dat_d[CAL_BIT] = calBusy_q;
        end
        IDX_HOOK2: dat_d[HS2_BIT] = hs2_q;
        IDX_QUENCH:
        begin
          dat_d[SQ1_BIT] = sq_q[1];
          dat_d[SQ0_BIT] = sq_q[0];
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      meta_q <= '0;
      sync_q <= '0;
      ack_q <= 1'b0;
      dat_q <= '0;
      oh_q <= 1'b0;
      onhook_monitor_enable_q <= 1'b0;
      tde_q <= 1'b0;
      rcd_q <= 1'b0;
      fw_q <= 1'b0;
      hs_q <= 1'b0;
      hs2_q <= 1'b0;
      sq_q <= 2'b00;
      gain_q <= 3'h0;
      ovr_q <= 1'b0;
      det_q <= 1'b0;
      ind_q <= 1'b0;
      rpos_q <= 1'b0;
      rneg_q <= 1'b0;
    end
    else
    begin
      meta_q <= lineIn;
      sync_q <= meta_q;
      ack_q <= ack_d;
      dat_q <= dat_d;
      oh_q <= oh_d;
      onhook_monitor_enable_q <= onhook_monitor_enable_d;
      tde_q <= tde_d;
      rcd_q <= rcd_d;
      fw_q <= fw_d;
      hs_q <= hs_d;
      hs2_q <= hs2_d;
      sq_q <= sq_d;
      gain_q <= gain_d;
      ovr_q <= ovr_d;
      det_q <= det_d;
      ind_q <= ind_d;
      rpos_q <= rpos_d;
      rneg_q <= rneg_d;
    end
  end

  // Hook state: a slow ramp walks loop current down one step per period
  always_comb
  begin
    hook_d = hook_q;
    level_d = level_q;
    step_d = '0;
    case (hook_q)
      HOOK_ON:
        if (oh_q)
        begin
          hook_d = HOOK_OFF;
          level_d = LEVEL_FULL;
        end
      HOOK_OFF:
        if (!oh_q)
        begin
          if (slow)
            hook_d = HOOK_RAMP;
          else
          begin
            hook_d = HOOK_ON;
            level_d = '0;
          end
        end
      HOOK_RAMP:
        if (oh_q)
        begin
          hook_d = HOOK_OFF;
          level_d = LEVEL_FULL;
        end
        else if (level_q == '0)
          hook_d = HOOK_ON;
        else if (step_q + 32'h1 >= stepLimit)
          level_d = level_q - 8'h01;
        else
          step_d = step_q + 32'h1;
      default: hook_d = HOOK_ON;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      hook_q <= HOOK_ON;
      level_q <= '0;
      step_q <= '0;
    end
    else
    begin
      hook_q <= hook_d;
      level_q <= level_d;
      step_q <= step_d;
    end
  end

  // Calibration after a tone; restarts if another tone ends meanwhile
  always_comb
  begin
    calBusy_d = calBusy_q;
    cal_d = cal_q;
    if (ind_q && !ind_d && hook_q == HOOK_OFF)
    begin
      calBusy_d = 1'b1;
      cal_d = CAL_COUNT;
    end
    else if (hook_q != HOOK_OFF)
    begin
      calBusy_d = 1'b0;
      cal_d = '0;
    end
    else if (calBusy_q)
    begin
      cal_d = cal_q - 32'h1;
      calBusy_d = cal_q > 32'h1;
    end
    out_d.offhook = hook_q != HOOK_ON;
    out_d.loopLevel = level_q;
    out_d.term800 = det_q;
    out_d.monitorActive = onhook_monitor_enable_q && hook_q == HOOK_ON;
    out_d.monitorGain = gain_q;
    out_d.ringDetect = rpos_q || (fw_q && rneg_q);
    out_d.calBusy = calBusy_q;
    out_d.txPermit = hook_q == HOOK_OFF && !calBusy_q;
    out_d.rcalDisable = rcd_q;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      calBusy_q <= 1'b0;
      cal_q <= '0;
      out_q <= '0;
    end
    else
    begin
      calBusy_q <= calBusy_d;
      cal_q <= cal_d;
      out_q <= out_d;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;
  assign lineOut = out_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  a_ack_single: assert property (ack_q |=> !ack_q)
    else $error("ack held two cycles");
  a_tone_gated: assert property (!tde_q |=> !ind_q && !$rose(ovr_q))
    else $error("tone logic active while disabled");
  a_ovr_set: assert property (
    toneOn && sync_q.amplitudeOver |=> ovr_q)
    else $error("overload flag not set");
  a_ovr_sticky: assert property (
    ovr_q && !(wrLow && idx == IDX_TONE && !dat_i[OVR_BIT]) |=> ovr_q)
    else $error("overload flag lost");
  a_det_term: assert property (
    toneOn && sync_q.supplyDepressed |=> ##1 lineOut.term800)
    else $error("800 ohm not applied");
  a_ind_follows: assert property (
    ind_q && !(toneOn && sync_q.toneActive) |=> !ind_q)
    else $error("indication stuck");
  a_cal_start: assert property (
    $fell(ind_q) && hook_q == HOOK_OFF |=> ##1 !lineOut.txPermit)
    else $error("tx allowed during calibration");
  a_ramp_lag: assert property (
    hook_q == HOOK_OFF && !oh_q && slow |=> ##1 lineOut.offhook)
    else $error("on-hook before ramp");
  a_halfwave: assert property (
    !fw_q && !oh_q |=> lineOut.ringDetect == $past(rpos_q))
    else $error("ring polarity mode wrong");
  a_monitor_on: assert property (
    onhook_monitor_enable_q && hook_q == HOOK_ON |=> lineOut.monitorActive)
    else $error("monitor not active");
endmodule : line_event_monitor
`default_nettype wire

// [dv/line_side_model.sv]
`timescale 1ns/100ps
`default_nettype none
module line_side_model
  import line_event_monitor_pkg::*;
(
  input wire logic tone,
  input wire logic surge,
  input wire logic ringPos,
  input wire logic ringNeg,
  output var line_in_type lineIn
);
  // A strong tone also drags the supply down and trips the amplitude limit;
  // a surge (parallel phone, reversal) only trips the amplitude limit
  assign lineIn = '{
    ringAbovePos: ringPos,
    ringBelowNeg: ringNeg,
    amplitudeOver: tone || surge,
    supplyDepressed: tone,
    toneActive: tone
  };
endmodule : line_side_model
`default_nettype wire

// [dv/tb_line_event_monitor.sv]
`timescale 1ns/100ps
`default_nettype none
module tb_line_event_monitor
  import line_event_monitor_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] sel = 4'hf;
  logic [ADR_W-1:0] adr = '0;
  logic [31:0] datW = '0;
  logic [31:0] datR;
  logic [31:0] rd;
  logic ack;
  logic tone = 1'b0;
  logic ringPos = 1'b0;
  logic ringNeg = 1'b0;
  logic surge = 1'b0;
  line_in_type lineIn;
  line_out_type lineOut;
  int miscompares = 0;
  int compares = 0;
  int cycles = 0;

  always #5 clk = ~clk;

  // Short counts keep the ramp near a thousand cycles
  line_event_monitor #(.CAL_COUNT(20), .STEP_COUNT(2)) dut (
    .clk(clk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(datW), .dat_o(datR), .ack_o(ack),
    .lineIn(lineIn), .lineOut(lineOut));

  line_side_model partner (
    .tone(tone), .surge(surge), .ringPos(ringPos), .ringNeg(ringNeg),
    .lineIn(lineIn));

  task end_of_test;
    if (miscompares == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task checkVal(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkVal

  task checkBit(input logic got, input logic exp);
    checkVal({31'h0, got}, {31'h0, exp});
  endtask : checkBit

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      end_of_test();
    end
  end

  task waitc(input int n);
    repeat (n) @(posedge clk);
  endtask : waitc

  task bus(input logic [6:0] idx, input logic w, input logic [7:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    datW <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1)
      @(posedge clk);
    rd = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus

  task wr(input logic [6:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask : wr

  task rdchk(input logic [6:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    checkVal(rd, {24'h0, exp});
  endtask : rdchk

  task test_unmapped;
    wr(7'h10, 8'hff);
    rdchk(7'h10, 8'h00);
  endtask : test_unmapped

  task test_tone_off;
    wr(IDX_LINE, 8'h01);
    tone <= 1'b1;
    waitc(10);
    rdchk(IDX_TONE, 8'h00);
    checkBit(lineOut.term800, 1'b0);
    tone <= 1'b0;
    waitc(10);
  endtask : test_tone_off

  task test_tone;
    wr(IDX_TONE, 8'h14);
    tone <= 1'b1;
    waitc(10);
    rdchk(IDX_TONE, 8'h17);
    rdchk(IDX_STAT, 8'h04);
    checkBit(lineOut.term800, 1'b1);
    checkBit(lineOut.rcalDisable, 1'b1);
    tone <= 1'b0;
    waitc(8);
    rdchk(IDX_STAT, 8'h10);
    checkBit(lineOut.txPermit, 1'b0);
    rdchk(IDX_TONE, 8'h17);
    wr(IDX_TONE, 8'h14);
    rdchk(IDX_TONE, 8'h14);
    checkBit(lineOut.term800, 1'b0);
    waitc(30);
    checkBit(lineOut.calBusy, 1'b0);
    checkBit(lineOut.txPermit, 1'b1);
    // A line surge alone must raise only the overload flag
    surge <= 1'b1;
    waitc(6);
    surge <= 1'b0;
    waitc(4);
    rdchk(IDX_TONE, 8'h16);
    rdchk(IDX_STAT, 8'h00);
    checkBit(lineOut.term800, 1'b0);
    wr(IDX_TONE, 8'h14);
    rdchk(IDX_TONE, 8'h14);
  endtask : test_tone

  task test_ramp;
    int n;
    n = 0;
    checkVal(32'(lineOut.loopLevel), 32'hff);
    wr(IDX_HOOK, 8'h40);
    rdchk(IDX_HOOK, 8'h40);
    wr(IDX_LINE, 8'h00);
    waitc(8);
    checkBit(lineOut.offhook, 1'b1);
    while (lineOut.offhook !== 1'b0)
    begin
      @(posedge clk);
      n++;
    end
    checkVal(32'(lineOut.loopLevel), 32'h0);
    // 255 steps of four cycles each, less the cycles already spent
    checkBit(n > 1000 && n < 1030, 1'b1);
    wr(IDX_HOOK, 8'h00);
    wr(IDX_LINE, 8'h01);
    waitc(8);
    wr(IDX_QUENCH, 8'h10);
    wr(IDX_HOOK2, 8'h08);
    rdchk(IDX_QUENCH, 8'h10);
    rdchk(IDX_HOOK2, 8'h08);
    wr(IDX_LINE, 8'h00);
    // Eight cycles a step now: two steps are taken by the time we look
    waitc(20);
    checkBit(lineOut.offhook, 1'b1);
    checkVal(32'(lineOut.loopLevel), 32'hfd);
    wr(IDX_LINE, 8'h01);
    waitc(4);
    checkVal(32'(lineOut.loopLevel), 32'hff);
    wr(IDX_QUENCH, 8'h00);
    wr(IDX_HOOK2, 8'h00);
    wr(IDX_LINE, 8'h00);
    waitc(6);
    checkBit(lineOut.offhook, 1'b0);
  endtask : test_ramp

  task test_ring;
    wr(IDX_LINE, 8'h08);
    wr(IDX_GAIN, 8'h05);
    wr(IDX_RING, 8'h00);
    ringNeg <= 1'b1;
    waitc(8);
    checkBit(lineOut.monitorActive, 1'b1);
    checkVal(32'(lineOut.monitorGain), 32'h5);
    checkBit(lineOut.ringDetect, 1'b0);
    rdchk(IDX_LINE, 8'h28);
    wr(IDX_RING, 8'h02);
    rdchk(IDX_RING, 8'h02);
    waitc(6);
    checkBit(lineOut.ringDetect, 1'b1);
    ringNeg <= 1'b0;
    ringPos <= 1'b1;
    wr(IDX_RING, 8'h00);
    waitc(6);
    checkBit(lineOut.ringDetect, 1'b1);
    rdchk(IDX_LINE, 8'h48);
    rdchk(IDX_GAIN, 8'h05);
    ringPos <= 1'b0;
    // Off-hook caller data uses the normal path, never the monitor
    wr(IDX_LINE, 8'h09);
    waitc(4);
    checkBit(lineOut.monitorActive, 1'b0);
    checkBit(lineOut.offhook, 1'b1);
    wr(IDX_LINE, 8'h00);
    waitc(6);
    checkBit(lineOut.monitorActive, 1'b0);
    checkBit(lineOut.ringDetect, 1'b0);
  endtask : test_ring

  initial
  begin
    waitc(2);
    reset <= 1'b0;
    test_unmapped();
    test_tone_off();
    test_tone();
    test_ramp();
    test_ring();
    end_of_test();
  end
endmodule : tb_line_event_monitor
`default_nettype wire
